// ==== hdl/sadc_ctrl.v ====
// Converter control top: APB register file, mode sequencing, stop-mode handling.
// Assumes clock is the high-frequency oscillator; stop_mode and cmp_high are async pins.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "sadc_map.vh"
module sadc_ctrl (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SADC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // System
  input wire stop_mode,
  // Analog front end
  input wire cmp_high,
  output reg [3:0] channel_select,
  output reg analog_input_disable,
  output reg sample_ff,
  output reg ladder_on_ff,
  output reg [`SADC_RES_W-1:0] dac_code_ff,
  // Event
  output reg conv_done_irq
);
  reg [7:0] ctrl_one_ff;
  reg [7:0] ctrl_two_ff;
  reg [7:0] res_high_ff;
  reg [1:0] res_low_ff;
  reg end_ff;
  reg [1:0] stop_sync_ff;
  reg [1:0] cmp_sync_ff;
  reg [`SADC_CNT_W-1:0] length_ff;
  reg start_ff;
  reg abort_ff;
  reg [7:0] nxt_rdata;
  wire stop_s;
  wire cmp_s;
  wire sar_busy;
  wire sar_done;
  wire [`SADC_RES_W-1:0] sar_trial;
  wire [`SADC_RES_W-1:0] sar_result;
  wire setup;
  wire wr_en;
  wire rd_en;
  wire [7:0] idx;
  wire [1:0] mode;
  wire mapped;
  wire wr_one;
  wire start_req;
  wire repeat_go;

  ////////////////////////////////////////////////////////////////////////////
  // Time code to cycle count
  function [`SADC_CNT_W-1:0] sadc_cycles;
    input [2:0] code;
    begin
      case (code)
        `SADC_TIME_78: sadc_cycles = `SADC_CYC_78;
        `SADC_TIME_156: sadc_cycles = `SADC_CYC_156;
        `SADC_TIME_312: sadc_cycles = `SADC_CYC_312;
        `SADC_TIME_624: sadc_cycles = `SADC_CYC_624;
        `SADC_TIME_1248: sadc_cycles = `SADC_CYC_1248;
        default: sadc_cycles = `SADC_CYC_1248;
      endcase
    end
  endfunction

  // Index decode, used by read and write paths
  function sadc_hit;
    input [7:0] a;
    input [7:0] want;
    begin
      sadc_hit = (a == want);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stop_sync_ff <= 2'h0;
      cmp_sync_ff <= 2'h0;
    end else begin
      stop_sync_ff <= {stop_sync_ff[0], stop_mode};
      cmp_sync_ff <= {cmp_sync_ff[0], cmp_high};
    end
  end
  assign stop_s = stop_sync_ff[1];
  assign cmp_s = cmp_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && pready && !pwrite;
  assign idx = paddr[9:2];
  assign mapped = (paddr[1:0] == 2'h0) && (sadc_hit(idx, `SADC_IDX_CTRL_ONE) ||
    sadc_hit(idx, `SADC_IDX_CTRL_TWO) || sadc_hit(idx, `SADC_IDX_RES_HIGH) ||
    sadc_hit(idx, `SADC_IDX_RES_LOW));
  assign mode = ctrl_one_ff[`SADC_C1_MODE_HI:`SADC_C1_MODE_LO];
  assign wr_one = wr_en && !stop_s && sadc_hit(idx, `SADC_IDX_CTRL_ONE);
  // A start needs a running mode; mode 10 is reserved and never starts
  assign start_req = wr_one && pwdata[`SADC_C1_START] &&
    ((pwdata[6:5] == `SADC_MODE_SOFT) || (pwdata[6:5] == `SADC_MODE_REPEAT));
  assign repeat_go = sar_done && (mode == `SADC_MODE_REPEAT) && !stop_s;

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: no wait states, ready registered
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup) begin
        prdata <= {24'h000000, nxt_rdata};
      end
    end
  end

  always @* begin
    nxt_rdata = 8'h00;
    if (sadc_hit(idx, `SADC_IDX_CTRL_ONE)) begin
      nxt_rdata = ctrl_one_ff;
    end else if (sadc_hit(idx, `SADC_IDX_CTRL_TWO)) begin
      nxt_rdata = {2'h0, ctrl_two_ff[5:0]};
    end else if (sadc_hit(idx, `SADC_IDX_RES_HIGH)) begin
      nxt_rdata = res_high_ff;
    end else if (sadc_hit(idx, `SADC_IDX_RES_LOW)) begin
      nxt_rdata = {res_low_ff, end_ff, sar_busy, 4'h0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_one_ff <= `SADC_C1_RESET;
      ctrl_two_ff <= `SADC_C2_RESET;
    end else if (stop_s) begin
      ctrl_one_ff <= `SADC_C1_RESET;
      ctrl_two_ff <= `SADC_C2_RESET;
    end else begin
      if (wr_one) begin
        // Start bit is never stored, so it reads back as zero
        ctrl_one_ff <= {1'b0, pwdata[6:0]};
      end
      if (wr_en && sadc_hit(idx, `SADC_IDX_CTRL_TWO)) begin
        ctrl_two_ff <= pwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing toward the approximation engine
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
      length_ff <= `SADC_CYC_1248;
    end else begin
      start_ff <= (start_req || repeat_go) && !stop_s;
      // Mode off or stop mode cancels a conversion in flight
      abort_ff <= stop_s || (wr_one && pwdata[6:5] == `SADC_MODE_OFF);
      if (start_req || repeat_go) begin
        length_ff <= sadc_cycles(ctrl_two_ff[`SADC_C2_TIME_HI:`SADC_C2_TIME_LO]);
      end
    end
  end

  sadc_sar u_sar (
    .clock(clock),
    .resetn(resetn),
    .start(start_ff),
    .abort(abort_ff),
    .length(length_ff),
    .cmp_high(cmp_s),
    .busy_ff(sar_busy),
    .done_ff(sar_done),
    .trial_ff(sar_trial),
    .result_ff(sar_result)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Results and end flag
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      res_high_ff <= 8'h00;
      res_low_ff <= 2'h0;
      end_ff <= 1'b0;
      conv_done_irq <= 1'b0;
    end else begin
      conv_done_irq <= sar_done && !abort_ff;
      if (stop_s) begin
        res_high_ff <= 8'h00;
        res_low_ff <= 2'h0;
        end_ff <= 1'b0;
      end else if (sar_done && !abort_ff) begin
        res_high_ff <= sar_result[9:2];
        res_low_ff <= sar_result[1:0];
        end_ff <= 1'b1;
      end else if (start_ff) begin
        end_ff <= 1'b0;
      end else if (rd_en && sadc_hit(idx, `SADC_IDX_RES_HIGH)) begin
        end_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog front-end controls
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      channel_select <= 4'h0;
      analog_input_disable <= 1'b1;
      sample_ff <= 1'b0;
      ladder_on_ff <= 1'b0;
      dac_code_ff <= {`SADC_RES_W{1'b0}};
    end else begin
      // Reserved channel codes park on the last input
      channel_select <= (ctrl_one_ff[`SADC_C1_CH_HI:`SADC_C1_CH_LO] > `SADC_CH_LAST) ?
        `SADC_CH_LAST : ctrl_one_ff[`SADC_C1_CH_HI:`SADC_C1_CH_LO];
      analog_input_disable <= ctrl_one_ff[`SADC_C1_AIN_DIS];
      sample_ff <= start_ff;
      ladder_on_ff <= !stop_s && (ctrl_two_ff[`SADC_C2_LADDER] || sar_busy);
      dac_code_ff <= sar_trial;
    end
  end
endmodule // sadc_ctrl

// ==== hdl/sadc_map.vh ====
// Constants for the converter control block: register indices, fields, resets, timing.
// Assumes inclusion by the two design files and the checker.
`ifndef SADC_MAP_VH
`define SADC_MAP_VH
// Register indices; byte address is four times the index
`define SADC_IDX_CTRL_ONE 8'h0E
`define SADC_IDX_CTRL_TWO 8'h0F
`define SADC_IDX_RES_HIGH 8'h20
`define SADC_IDX_RES_LOW 8'h21
`define SADC_ADDR_W 10
// Control one fields
`define SADC_C1_START 7
`define SADC_C1_MODE_HI 6
`define SADC_C1_MODE_LO 5
`define SADC_C1_AIN_DIS 4
`define SADC_C1_CH_HI 3
`define SADC_C1_CH_LO 0
`define SADC_C1_RESET 8'h10
// Control two fields
`define SADC_C2_LADDER 5
`define SADC_C2_FIXED_ONE 4
`define SADC_C2_TIME_HI 3
`define SADC_C2_TIME_LO 1
`define SADC_C2_RESET 8'h10
// Result low/status fields
`define SADC_R2_END 5
`define SADC_R2_BUSY 4
// Mode codes
`define SADC_MODE_OFF 2'h0
`define SADC_MODE_SOFT 2'h1
`define SADC_MODE_REPEAT 2'h3
// Channel codes
`define SADC_CH_LAST 4'h5
// Conversion time codes and lengths in oscillator cycles
`define SADC_TIME_78 3'h2
`define SADC_TIME_156 3'h3
`define SADC_TIME_312 3'h4
`define SADC_TIME_624 3'h5
`define SADC_TIME_1248 3'h6
`define SADC_CYC_78 11'h04E
`define SADC_CYC_156 11'h09C
`define SADC_CYC_312 11'h138
`define SADC_CYC_624 11'h270
`define SADC_CYC_1248 11'h4E0
`define SADC_CNT_W 11
`define SADC_RES_W 10
`endif

// ==== hdl/sadc_sar.v ====
// Successive approximation sequencer: ten trial bits spread over the conversion time.
// Assumes the analog comparator result is already synchronised to clock.
`timescale 1ns/1ps
`include "sadc_map.vh"
module sadc_sar (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Control
  input wire start,
  input wire abort,
  input wire [`SADC_CNT_W-1:0] length,
  // Comparator
  input wire cmp_high,
  // Status and result
  output reg busy_ff,
  output reg done_ff,
  output reg [`SADC_RES_W-1:0] trial_ff,
  output reg [`SADC_RES_W-1:0] result_ff
);
  reg [`SADC_CNT_W-1:0] cnt_ff;
  reg [`SADC_RES_W-1:0] bit_ff;
  wire [`SADC_CNT_W-1:0] step;
  wire [`SADC_CNT_W-1:0] elapsed;
  wire step_tick;
  ////////////////////////////////////////////////////////////////////////////
  // Ten trials spaced from the start, so the first waits out the comparator path
  assign step = length / `SADC_CNT_W'd10;
  assign elapsed = length - `SADC_CNT_W'd1 - cnt_ff;
  assign step_tick = (elapsed != {`SADC_CNT_W{1'b0}}) &&
    (elapsed % step == {`SADC_CNT_W{1'b0}});
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff <= {`SADC_CNT_W{1'b0}};
      bit_ff <= {`SADC_RES_W{1'b0}};
      trial_ff <= {`SADC_RES_W{1'b0}};
      result_ff <= {`SADC_RES_W{1'b0}};
    end else begin
      done_ff <= 1'b0;
      if (abort) begin
        busy_ff <= 1'b0;
        cnt_ff <= {`SADC_CNT_W{1'b0}};
      end else if (start) begin
        busy_ff <= 1'b1;
        cnt_ff <= length - `SADC_CNT_W'd1;
        bit_ff <= {1'b1, {(`SADC_RES_W-1){1'b0}}};
        trial_ff <= {1'b1, {(`SADC_RES_W-1){1'b0}}};
      end else if (busy_ff) begin
        if (cnt_ff == {`SADC_CNT_W{1'b0}}) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          result_ff <= trial_ff;
        end else begin
          cnt_ff <= cnt_ff - `SADC_CNT_W'd1;
          if (step_tick && bit_ff != {`SADC_RES_W{1'b0}}) begin
            trial_ff <= (cmp_high ? trial_ff : (trial_ff & ~bit_ff)) | (bit_ff >> 1);
            bit_ff <= bit_ff >> 1;
          end
        end
      end
    end
  end
endmodule // sadc_sar

// ==== testbench/sadc_afe_model.sv ====
// Analog front end model: one sample-hold for the selected channel and comparator.
// Assumes the converter pulses sample_ff at the start of every conversion.
`timescale 1ns/1ps
module sadc_afe_model #(parameter logic [59:0] LEVELS = 60'h0) (
  // Clock
  input wire clock,
  // From converter
  input wire [3:0] channel_select,
  input wire analog_input_disable,
  input wire sample_ff,
  input wire [9:0] dac_code_ff,
  // To converter
  output logic cmp_high
);
  logic [9:0] held = 10'h000;
  ////////////////////////////////////////
  // Hold the selected input; a disabled input reads zero
  always @(posedge clock) begin
    if (sample_ff) begin
      held <= analog_input_disable ? 10'h000 : LEVELS[channel_select*10 +: 10];
    end
  end
  assign cmp_high = held >= dac_code_ff;
endmodule // sadc_afe_model

// ==== testbench/sadc_checker.sv ====
// Checker for the converter control block.
// Assumes binding to sadc_ctrl with one clock domain.
`timescale 1ns/1ps
`include "sadc_map.vh"
module sadc_checker (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SADC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // System and front end
  input wire stop_mode,
  input wire cmp_high,
  input wire [3:0] channel_select,
  input wire analog_input_disable,
  input wire sample_ff,
  input wire ladder_on_ff,
  input wire [`SADC_RES_W-1:0] dac_code_ff,
  input wire conv_done_irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  reg [11:0] cnt_ff;
  reg [2:0] time_ff;
  reg [1:0] mode_ff;
  reg [11:0] len;
  wire wr_ok = psel && penable && pready && pwrite && !stop_mode;
  wire wr_one = wr_ok && paddr == 10'h038;
  ////////////////////////////////////////
  // Expected length and cycles since the last start or finish
  always @* begin
    case (time_ff)
      3'h2: len = 12'h04E;
      3'h3: len = 12'h09C;
      3'h4: len = 12'h138;
      3'h5: len = 12'h270;
      default: len = 12'h4E0;
    endcase
  end
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 12'h000;
      time_ff <= 3'h0;
      mode_ff <= 2'h0;
    end else begin
      cnt_ff <= (sample_ff || conv_done_irq) ? 12'h000 : cnt_ff + {11'h000, cnt_ff != 12'hFFF};
      if (stop_mode) begin
        time_ff <= 3'h0;
        mode_ff <= 2'h0;
      end else begin
        if (wr_one) mode_ff <= pwdata[6:5];
        if (wr_ok && paddr == 10'h03C) time_ff <= pwdata[3:1];
      end
    end
  end
  ////////////////////////////////////////
  AST_SOFT_START: assert property (
    wr_one && pwdata[7:5] == 3'h5 |-> ##[1:3] sample_ff)
    else $error("start write gave no conversion");
  AST_SINGLE_ONCE: assert property (
    conv_done_irq && mode_ff == 2'h1 |=> !sample_ff [*3])
    else $error("single mode restarted");
  AST_REPEAT: assert property (
    conv_done_irq && mode_ff == 2'h3 |-> ##[1:3] sample_ff)
    else $error("repeat mode did not restart");
  AST_CONV_TIME: assert property (
    conv_done_irq |-> cnt_ff + 12'h003 >= len && cnt_ff <= len + 12'h004)
    else $error("conversion length wrong");
  AST_IRQ_PULSE: assert property (conv_done_irq |=> !conv_done_irq)
    else $error("done pulse too long");
  AST_ABORT: assert property (
    wr_one && pwdata[6:5] == 2'h0 |=> !conv_done_irq [*8])
    else $error("finish after abort");
  AST_LADDER: assert property (sample_ff |-> ##4 ladder_on_ff)
    else $error("ladder off while converting");
  AST_STOP_INIT: assert property (
    stop_mode [*5] |-> analog_input_disable && channel_select == 4'h0 && !conv_done_irq)
    else $error("stop mode did not initialise");
  AST_CHANNEL: assert property (channel_select <= 4'h5)
    else $error("channel out of range");
  COV_REPEAT: cover property (conv_done_irq && mode_ff == 2'h3);
  COV_SINGLE: cover property (conv_done_irq && mode_ff == 2'h1);
  COV_ABORT: cover property (wr_one && pwdata[6:5] == 2'h0 && mode_ff == 2'h3);
endmodule // sadc_checker
bind sadc_ctrl sadc_checker u_chk (.clock(clock), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode), .cmp_high(cmp_high),
  .channel_select(channel_select), .analog_input_disable(analog_input_disable),
  .sample_ff(sample_ff), .ladder_on_ff(ladder_on_ff), .dac_code_ff(dac_code_ff),
  .conv_done_irq(conv_done_irq));

// ==== testbench/sar_adc_control_bench.sv ====
// Testbench for the converter control block over APB.
// Assumes the front end model answers the comparator.
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module sar_adc_control_bench;
  localparam logic [59:0] LV = {10'h0FE, 10'h201, 10'h2AA, 10'h155, 10'h3FF, 10'h000};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic stop_mode = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, cmp_high, analog_input_disable, sample_ff, ladder_on_ff, conv_done_irq;
  logic [3:0] channel_select;
  logic [9:0] dac_code_ff;
  logic [7:0] q, serr;
  logic [7:0] nogo [2] = '{8'h82, 8'hC2};
  int err_count = 0;
  int compares = 0;
  int irqs = 0;
  int cyc = 0;
  int n, k;
  always #2 clock = ~clock;
  always @(posedge clock) begin
    if (conv_done_irq === 1'b1) irqs++;
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      final_report();
    end
  end
  sadc_ctrl u_dut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stop_mode(stop_mode), .cmp_high(cmp_high),
    .channel_select(channel_select), .analog_input_disable(analog_input_disable),
    .sample_ff(sample_ff), .ladder_on_ff(ladder_on_ff), .dac_code_ff(dac_code_ff),
    .conv_done_irq(conv_done_irq));
  sadc_afe_model #(.LEVELS(LV)) u_afe (.clock(clock), .channel_select(channel_select),
    .analog_input_disable(analog_input_disable), .sample_ff(sample_ff),
    .dac_code_ff(dac_code_ff), .cmp_high(cmp_high));
  ////////////////////////////////////////
  task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata[7:0];
    serr = {7'h00, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, a, 8'h00);
    `CHK("read", e & m, q & m)
  endtask
  task automatic wait_end();
    q = 8'h00;
    for (k = 0; k < 700 && q[5] !== 1'b1; k++) apb(1'b0, 10'h084, 8'h00);
  endtask
  task automatic conv(input int ch);
    logic [9:0] v;
    v = LV[ch*10 +: 10];
    rd(10'h084, 8'h10, 8'h30);
    wait_end();
    `CHK("status", {v[1:0], 2'b10}, q[7:4])
    rd(10'h080, v[9:2], 8'hFF);
    rd(10'h084, {v[1:0], 6'h00}, 8'hF0);
  endtask
  task automatic final_report();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(10'h038, 8'h10, 8'hFF);
    rd(10'h03C, 8'h10, 8'h3F);
    rd(10'h080, 8'h00, 8'hFF);
    rd(10'h084, 8'h00, 8'hF0);
    apb(1'b0, 10'h100, 8'h00);
    `CHK("slverr", 8'h01, serr)
    apb(1'b1, 10'h080, 8'h55);
    rd(10'h080, 8'h00, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 10'h03C, {4'hD, 3'(2 + i % 5), 1'b0});
      rd(10'h03C, {4'h1, 3'(2 + i % 5), 1'b0}, 8'h3F);
      apb(1'b1, 10'h038, 8'hA0 | 8'(i));
      rd(10'h038, 8'h20 | 8'(i), 8'hFF);
      conv(i);
    end
    apb(1'b1, 10'h03C, 8'h14);
    apb(1'b1, 10'h038, 8'hA0);
    wait_end();
    apb(1'b1, 10'h038, 8'hA1);
    rd(10'h084, 8'h10, 8'hF0);
    rd(10'h080, 8'h00, 8'hFF);
    conv(1);
    n = irqs;
    apb(1'b1, 10'h038, 8'hE2);
    repeat (200) @(posedge clock);
    `CHK("repeat", 1'b1, irqs - n >= 2)
    // Abort well inside a conversion, clear of a completion edge
    while (conv_done_irq !== 1'b1) @(posedge clock);
    repeat (10) @(posedge clock);
    apb(1'b1, 10'h038, 8'h02);
    n = irqs;
    repeat (200) @(posedge clock);
    `CHK("abort", n, irqs)
    rd(10'h084, {LV[21:20], 6'h00}, 8'hF0);
    rd(10'h080, LV[29:22], 8'hFF);
    foreach (nogo[j]) begin
      n = irqs;
      apb(1'b1, 10'h038, nogo[j]);
      repeat (100) @(posedge clock);
      `CHK("no run", n, irqs)
    end
    apb(1'b1, 10'h038, 8'h13);
    @(negedge clock);
    `CHK("disable", 1'b1, analog_input_disable)
    `CHK("channel", 4'h3, channel_select)
    @(posedge clock);
    apb(1'b1, 10'h038, 8'h1E);
    @(negedge clock);
    `CHK("channel", 4'h5, channel_select)
    @(posedge clock);
    apb(1'b1, 10'h03C, 8'h34);
    @(negedge clock);
    `CHK("ladder", 1'b1, ladder_on_ff)
    @(posedge clock);
    apb(1'b1, 10'h03C, 8'h14);
    @(negedge clock);
    `CHK("ladder", 1'b0, ladder_on_ff)
    @(posedge clock);
    apb(1'b1, 10'h038, 8'hA3);
    rd(10'h084, 8'h10, 8'h10);
    repeat (4) @(posedge clock);
    stop_mode <= 1'b1;
    repeat (4) @(posedge clock);
    apb(1'b1, 10'h038, 8'h25);
    apb(1'b1, 10'h03C, 8'h36);
    rd(10'h038, 8'h10, 8'hFF);
    rd(10'h03C, 8'h10, 8'h3F);
    rd(10'h084, 8'h00, 8'hF0);
    stop_mode <= 1'b0;
    repeat (4) @(posedge clock);
    apb(1'b1, 10'h038, 8'h24);
    rd(10'h038, 8'h24, 8'hFF);
    final_report();
  end
endmodule // sar_adc_control_bench
